// [hdl/canopen_nmt_node.sv]
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "canopen_nmt_regs.svh"
module canopen_nmt_node #(
  parameter int CHANNELS     = 8,
  parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_SEC
) (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  can_link_if.node                 link,
  input  wire logic [6:0]          nodeId,
  input  wire logic [CHANNELS-1:0] processOutputs,
  input  wire logic [CHANNELS-1:0] faultEnable,
  input  wire logic [CHANNELS-1:0] faultValue,
  output logic      [CHANNELS-1:0] channelOutputs,
  output logic                     run_indicator,
  output logic                     guardFailure,
  output logic      [6:0]          stateCode
);
  canopen_nmt_pkg::nmt_state_type state;
  logic [15:0] guardTime;
  logic [7:0]  lifeFactor;
  logic [23:0] lifeTime;
  logic [23:0] msCount;
  logic        guardActive;
  logic        toggle;
  logic [31:0] divCount;
  logic        msTick;
  logic [8:0]  blinkCount;
  logic        emcyPending;
  logic        guardPending;
  logic        sdoPending;
  logic [23:0] sdoAckMux;
  logic        rxTake;
  logic        isNmt;
  logic        isGuard;
  logic        isSdo;
  logic [7:0]  cs;
  logic [15:0] sdoIndex;
  logic        commReset;
  logic [6:0]  next_code;

  assign rxTake   = link.m2nValid & link.m2nReady;
  assign cs       = link.m2nData[7:0];
  assign sdoIndex = link.m2nData[23:8];
  assign isNmt    = rxTake & (link.m2nId == `COB_NMT) & ~link.m2nRtr
                    & (link.m2nData[15:8] == {1'b0, nodeId});
  // guard request on 0x700 plus node
  assign isGuard  = rxTake & link.m2nRtr & (link.m2nId == (`COB_GUARD | {4'h0, nodeId}));
  assign isSdo    = rxTake & ~link.m2nRtr & (link.m2nId == (`COB_SDO_RX | {4'h0, nodeId}));
  assign commReset = isNmt & ((cs == `NMT_RESET_NODE) | (cs == `NMT_RESET_COMM));
  assign lifeTime  = guardTime * lifeFactor;

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || divCount == 32'(CYCLES_PER_MS - 1)) begin
      divCount <= 32'h0;
    end else begin
      divCount <= divCount + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    msTick <= ~reset & (divCount == 32'(CYCLES_PER_MS - 1));
  end

  // ------------------------------------------------------------
  // Network state
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= canopen_nmt_pkg::NMT_INIT;
    end else begin
      unique case (state)
        canopen_nmt_pkg::NMT_INIT: begin
          state <= canopen_nmt_pkg::NMT_PREOP;
        end
        canopen_nmt_pkg::NMT_PREOP, canopen_nmt_pkg::NMT_OPER, canopen_nmt_pkg::NMT_STOPPED: begin
          if (isNmt) begin
            if (cs == `NMT_START) begin
              state <= canopen_nmt_pkg::NMT_OPER;
            end else if (cs == `NMT_STOP) begin
              state <= canopen_nmt_pkg::NMT_STOPPED;
            end else if (cs == `NMT_PREOP) begin
              state <= canopen_nmt_pkg::NMT_PREOP;
            end else if (commReset) begin
              state <= canopen_nmt_pkg::NMT_INIT;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    unique case (state)
      canopen_nmt_pkg::NMT_OPER:    next_code = `CODE_OPER;
      canopen_nmt_pkg::NMT_STOPPED: next_code = `CODE_STOPPED;
      canopen_nmt_pkg::NMT_PREOP:   next_code = `CODE_PREOP;
      canopen_nmt_pkg::NMT_INIT:    next_code = `CODE_PREOP;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stateCode <= `CODE_PREOP;
    end else begin
      stateCode <= next_code;
    end
  end

  // ------------------------------------------------------------
  // Run indicator
  // ------------------------------------------------------------
  // blink in pre-operational
  always_ff @(posedge ref_clk) begin
    if (reset || state != canopen_nmt_pkg::NMT_PREOP) begin
      blinkCount    <= 9'h0;
      run_indicator <= (state == canopen_nmt_pkg::NMT_OPER) & ~reset;
    end else if (msTick) begin
      if (blinkCount == 9'(`BLINK_HALF_MS - 1)) begin
        blinkCount    <= 9'h0;
        run_indicator <= ~run_indicator;
      end else begin
        blinkCount <= blinkCount + 9'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Guard configuration
  // ------------------------------------------------------------
  // store guard objects
  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      guardTime  <= 16'h0;
      lifeFactor <= 8'h0;
    end else if (isSdo && sdoIndex == `IDX_GUARD_TIME && cs == `SDO_DL_2BYTE) begin
      guardTime <= link.m2nData[47:32];
    end else if (isSdo && sdoIndex == `IDX_LIFE_FACT && cs == `SDO_DL_1BYTE) begin
      lifeFactor <= link.m2nData[39:32];
    end
  end

  // ------------------------------------------------------------
  // Guard timer
  // ------------------------------------------------------------
  // timer armed by first request
  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      guardActive <= 1'b0;
    end else if (isGuard) begin
      guardActive <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || commReset || isGuard || !guardActive) begin
      msCount <= 24'h0;
    end else if (msTick && !guardFailure) begin
      msCount <= msCount + 24'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      guardFailure <= 1'b0;
    end else if (guardActive && lifeTime != 24'h0 && msCount >= lifeTime) begin
      guardFailure <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Transmit requests and toggle
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      emcyPending <= 1'b0;
    end else if (guardActive && lifeTime != 24'h0 && msCount >= lifeTime && !guardFailure) begin
      emcyPending <= 1'b1;
    end else if (!link.n2mValid) begin
      emcyPending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      guardPending <= 1'b0;
    end else if (isGuard) begin
      guardPending <= 1'b1;
    end else if (!link.n2mValid && !emcyPending) begin
      guardPending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      sdoPending <= 1'b0;
      sdoAckMux  <= 24'h0;
    end else if (isSdo && (cs == `SDO_DL_2BYTE || cs == `SDO_DL_1BYTE)
                 && (sdoIndex == `IDX_GUARD_TIME || sdoIndex == `IDX_LIFE_FACT)) begin
      sdoPending <= 1'b1;
      sdoAckMux  <= link.m2nData[31:8];
    end else if (!link.n2mValid && !emcyPending && !guardPending) begin
      sdoPending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      toggle <= 1'b0;
    end else if (!link.n2mValid && !emcyPending && guardPending) begin
      toggle <= ~toggle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link.n2mValid <= 1'b0;
      link.n2mId    <= 11'h0;
      link.n2mDlc   <= 4'h0;
      link.n2mData  <= 64'h0;
    end else if (link.n2mValid) begin
      link.n2mValid <= ~link.n2mReady;
    end else if (emcyPending) begin
      link.n2mValid <= 1'b1;
      link.n2mId    <= `COB_EMCY_BASE | {4'h0, nodeId};
      link.n2mDlc   <= 4'h8;
      link.n2mData  <= `EMCY_GUARD;
    end else if (guardPending) begin
      // toggle and code in one byte
      link.n2mValid <= 1'b1;
      link.n2mId    <= `COB_GUARD | {4'h0, nodeId};
      link.n2mDlc   <= 4'h1;
      link.n2mData  <= {56'h0, toggle, stateCode};
    end else if (sdoPending) begin
      link.n2mValid <= 1'b1;
      link.n2mId    <= `COB_SDO_TX | {4'h0, nodeId};
      link.n2mDlc   <= 4'h8;
      link.n2mData  <= {32'h0, sdoAckMux, `SDO_DL_ACK};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link.m2nReady <= 1'b0;
    end else begin
      link.m2nReady <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Output channels
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          channelOutputs[ch] <= 1'b0;
        end else if (guardFailure && faultEnable[ch]) begin
          channelOutputs[ch] <= faultValue[ch];
        end else if (state == canopen_nmt_pkg::NMT_OPER) begin
          channelOutputs[ch] <= processOutputs[ch];
        end
      end
    end
  endgenerate
endmodule : canopen_nmt_node

// [hdl/canopen_nmt_regs.svh]
`ifndef CANOPEN_NMT_REGS_SVH
`define CANOPEN_NMT_REGS_SVH
// Function
// - Enters pre-operational by itself after initialisation
// - Pre-operational blinks run indicator twice per second
// - Start command 1 with node id -> operational
// - Decode stop, pre-op, reset node, reset comm
// - Guard time 0x100C, life factor 0x100D stored
// - Life time is guard time times factor
// - Guard timer runs only after first request
// - Master guards with empty remote frame 0x700+node
// - Toggle bit inverts between consecutive responses
// - First response after activation has toggle zero
// - State codes 4 stopped, 5 operational, 127 pre-op
// - Expedited writes use 0x2B and 0x2F
// - Write acknowledged with 0x60, index, subindex, zeros
// - Master repeats guard request within life time; master here sends one request per OP_GUARD command, no repeat timer
// - Missed guard raises error and emergency message
// - Emergency bytes 30 81 11 07 then zeros
// - Guard failure forces outputs to fault values

// ------------------------------------------------------------
// Frame identifiers and command codes
// ------------------------------------------------------------
`define COB_NMT        11'h000
`define COB_EMCY_BASE  11'h080
`define COB_SDO_TX     11'h580
`define COB_SDO_RX     11'h600
`define COB_GUARD      11'h700
`define NMT_START      8'h01
`define NMT_STOP       8'h02
`define NMT_PREOP      8'h80
`define NMT_RESET_NODE 8'h81
`define NMT_RESET_COMM 8'h82
`define SDO_DL_2BYTE   8'h2b
`define SDO_DL_1BYTE   8'h2f
`define SDO_DL_ACK     8'h60
`define IDX_GUARD_TIME 16'h100c
`define IDX_LIFE_FACT  16'h100d
`define CODE_STOPPED   7'h04
`define CODE_OPER      7'h05
`define CODE_PREOP     7'h7f
`define EMCY_GUARD     64'h0000_0000_0711_8130
`define TOGGLE_BIT     7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ         20000000
`define MS_PER_SEC     1000
`define BLINK_HALF_MS  250

// ------------------------------------------------------------
// Controller registers (APB byte offsets)
// ------------------------------------------------------------
`define REG_CMD        12'h000
`define REG_DATA       12'h004
`define REG_NODE       12'h008
`define REG_STATUS     12'h00c
`define REG_INT_STAT   12'h010
`define REG_INT_MASK   12'h014
`define OP_NMT         3'h1
`define OP_SDO16       3'h2
`define OP_SDO8        3'h3
`define OP_GUARD       3'h4
`define INT_GUARD_RESP 0
`define INT_SDO_ACK    1
`define INT_EMCY       2
`define INT_BITS       3
`endif

// [hdl/canopen_nmt_pkg.sv]
package canopen_nmt_pkg;
  typedef enum logic [1:0] {
    NMT_INIT    = 2'b00,
    NMT_PREOP   = 2'b01,
    NMT_OPER    = 2'b10,
    NMT_STOPPED = 2'b11
  } nmt_state_type;
  typedef logic [63:0] frame_data_type;
endpackage : canopen_nmt_pkg

// [hdl/can_link_if.sv]
`timescale 1ns/1ns
interface can_link_if;
  // Master to node
  logic                          m2nValid;
  logic                          m2nReady;
  logic [10:0]                   m2nId;
  logic                          m2nRtr;
  logic [3:0]                    m2nDlc;
  canopen_nmt_pkg::frame_data_type m2nData;
  // Node to master
  logic                          n2mValid;
  logic                          n2mReady;
  logic [10:0]                   n2mId;
  logic [3:0]                    n2mDlc;
  canopen_nmt_pkg::frame_data_type n2mData;

  modport node (
    input  m2nValid, m2nId, m2nRtr, m2nDlc, m2nData, n2mReady,
    output m2nReady, n2mValid, n2mId, n2mDlc, n2mData
  );
  modport master (
    output m2nValid, m2nId, m2nRtr, m2nDlc, m2nData, n2mReady,
    input  m2nReady, n2mValid, n2mId, n2mDlc, n2mData
  );
endinterface : can_link_if

// [hdl/canopen_nmt_master.sv]
`timescale 1ns/1ns
`include "canopen_nmt_regs.svh"
module canopen_nmt_master (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  can_link_if.master       link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  logic [6:0]           targetNode;
  logic [15:0]          dataValue;
  logic [`INT_BITS-1:0] intStatus;
  logic [`INT_BITS-1:0] intMask;
  logic [`INT_BITS-1:0] events;
  logic [7:0]           guardByte;
  logic [7:0]           lastAckCmd;
  logic                 wrAccess;
  logic                 rdAccess;
  logic                 rxTake;
  logic [31:0]          next_prdata;

  assign wrAccess = psel & penable & pwrite & pready;
  assign rdAccess = psel & ~penable & ~pwrite;
  assign rxTake   = link.n2mValid & link.n2mReady;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `REG_INT_MASK);
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      `REG_DATA:     next_prdata = {16'h0, dataValue};
      `REG_NODE:     next_prdata = {25'h0, targetNode};
      `REG_STATUS:   next_prdata = {15'h0, link.m2nValid, lastAckCmd, guardByte};
      `REG_INT_STAT: next_prdata = {29'h0, intStatus};
      `REG_INT_MASK: next_prdata = {29'h0, intMask};
      default:       next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (rdAccess) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      targetNode <= 7'h1;
      dataValue  <= 16'h0;
      intMask    <= 3'h0;
    end else if (wrAccess) begin
      if (paddr == `REG_NODE) targetNode <= pwdata[6:0];
      if (paddr == `REG_DATA) dataValue <= pwdata[15:0];
      if (paddr == `REG_INT_MASK) intMask <= pwdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupts: set wins over write-one clear
  // ------------------------------------------------------------
  assign events[`INT_GUARD_RESP] = rxTake & (link.n2mId == (`COB_GUARD | {4'h0, targetNode}));
  assign events[`INT_SDO_ACK]    = rxTake & (link.n2mId == (`COB_SDO_TX | {4'h0, targetNode}));
  assign events[`INT_EMCY]       = rxTake & (link.n2mId == (`COB_EMCY_BASE | {4'h0, targetNode}));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intStatus <= 3'h0;
    end else begin
      intStatus <= (intStatus & ~((wrAccess && paddr == `REG_INT_STAT) ? pwdata[2:0] : 3'h0)) | events;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      guardByte  <= 8'h0;
      lastAckCmd <= 8'h0;
    end else if (events[`INT_GUARD_RESP]) begin
      guardByte <= link.n2mData[7:0];
    end else if (events[`INT_SDO_ACK]) begin
      lastAckCmd <= link.n2mData[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    link.n2mReady <= ~reset;
  end

  // ------------------------------------------------------------
  // Frame issue; a command while busy is ignored
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link.m2nValid <= 1'b0;
      link.m2nId    <= 11'h0;
      link.m2nRtr   <= 1'b0;
      link.m2nDlc   <= 4'h0;
      link.m2nData  <= 64'h0;
    end else if (link.m2nValid) begin
      link.m2nValid <= ~link.m2nReady;
    end else if (wrAccess && paddr == `REG_CMD) begin
      link.m2nRtr  <= 1'b0;
      link.m2nDlc  <= 4'h8;
      unique case (pwdata[2:0])
        `OP_NMT: begin
          link.m2nValid <= 1'b1;
          link.m2nId    <= `COB_NMT;
          link.m2nDlc   <= 4'h2;
          link.m2nData  <= {48'h0, 1'b0, targetNode, pwdata[15:8]};
        end
        `OP_SDO16: begin
          link.m2nValid <= 1'b1;
          link.m2nId    <= `COB_SDO_RX | {4'h0, targetNode};
          link.m2nData  <= {16'h0, dataValue, 8'h0, pwdata[31:16], `SDO_DL_2BYTE};
        end
        `OP_SDO8: begin
          link.m2nValid <= 1'b1;
          link.m2nId    <= `COB_SDO_RX | {4'h0, targetNode};
          link.m2nData  <= {24'h0, dataValue[7:0], 8'h0, pwdata[31:16], `SDO_DL_1BYTE};
        end
        `OP_GUARD: begin
          link.m2nValid <= 1'b1;
          link.m2nId    <= `COB_GUARD | {4'h0, targetNode};
          link.m2nRtr   <= 1'b1;
          link.m2nDlc   <= 4'h0;
          link.m2nData  <= 64'h0;
        end
        default: begin
          link.m2nValid <= 1'b0;
        end
      endcase
    end
  end
endmodule : canopen_nmt_master

// [tb/canopen_nmt_monitor.sv]
`timescale 1ns/1ns
module canopen_nmt_monitor #(
  parameter logic [6:0] NODE = 7'h05
) (
  input wire logic                            ref_clk,
  input wire logic                            reset,
  input wire logic                            m2nValid,
  input wire logic                            m2nReady,
  input wire logic [10:0]                     m2nId,
  input wire logic                            m2nRtr,
  input wire logic [3:0]                      m2nDlc,
  input wire canopen_nmt_pkg::frame_data_type m2nData,
  input wire logic                            n2mValid,
  input wire logic                            n2mReady,
  input wire logic [10:0]                     n2mId,
  input wire logic [3:0]                      n2mDlc,
  input wire canopen_nmt_pkg::frame_data_type n2mData
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic        seenResp;
  logic        lastToggle;
  logic [23:0] sdoIdx;
  logic        mXfer;
  logic        gXfer;
  logic        guardReq;
  logic        sdoReq;
  logic        commReset;
  assign mXfer     = m2nValid && m2nReady;
  assign gXfer     = n2mValid && n2mReady && n2mId == {4'he, NODE};
  assign guardReq  = mXfer && m2nRtr && m2nId == {4'he, NODE} && m2nDlc == 4'h0;
  assign sdoReq    = mXfer && m2nId == {4'hc, NODE};
  assign commReset = mXfer && m2nId == 11'h000 && m2nData[15:8] == {1'b0, NODE} && m2nData[7:0] inside {8'h81, 8'h82};
  // Toggle history restarts with a node or communication reset
  always_ff @(posedge ref_clk) begin
    if (reset || commReset) begin
      seenResp <= 1'b0;
    end else if (gXfer) begin
      seenResp <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (gXfer) begin
      lastToggle <= n2mData[7];
    end
    if (sdoReq) begin
      sdoIdx <= m2nData[31:8];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_guard_answer;
    guardReq |-> ##[1:8] (n2mValid && n2mId == {4'he, NODE} && n2mDlc == 4'h1);
  endproperty
  a_guard_answer: assert property (p_guard_answer) else $error("guard request not answered");
  property p_guard_code;
    n2mValid && n2mId == {4'he, NODE} |-> n2mData[6:0] inside {7'h04, 7'h05, 7'h7f} && n2mData[63:8] == 56'h0;
  endproperty
  a_guard_code: assert property (p_guard_code) else $error("bad guard response byte");
  property p_toggle;
    gXfer && seenResp |-> n2mData[7] != lastToggle;
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit not inverted");
  property p_first_zero;
    gXfer && !seenResp |-> !n2mData[7];
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first toggle not zero");
  property p_sdo_cmd;
    sdoReq |-> m2nDlc == 4'h8 && m2nData[7:0] inside {8'h2b, 8'h2f};
  endproperty
  a_sdo_cmd: assert property (p_sdo_cmd) else $error("bad download command");
  property p_ack;
    sdoReq |=> ##[0:7] (n2mValid && n2mId == {4'hb, NODE} && n2mData == {32'h0, sdoIdx, 8'h60});
  endproperty
  a_ack: assert property (p_ack) else $error("download not acknowledged");
  property p_emcy;
    n2mValid && n2mId == {4'h1, NODE} |-> n2mDlc == 4'h8 && n2mData == 64'h0000_0000_0711_8130;
  endproperty
  a_emcy: assert property (p_emcy) else $error("bad emergency frame");
  property p_hold;
    n2mValid && !n2mReady |=> n2mValid && $stable(n2mData) && $stable(n2mId);
  endproperty
  a_hold: assert property (p_hold) else $error("node frame dropped before taken");
  c_guard: cover property (gXfer);
  c_emcy: cover property (n2mValid && n2mId == {4'h1, NODE});
  c_sdo: cover property (sdoReq);
endmodule : canopen_nmt_monitor

// [tb/canopen_nmt_node_guarding_bench.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errTotal++; $display("ERROR at %0t: got %0h expected %0h", $time, (a), (e)); end end
module canopen_nmt_node_guarding_bench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [7:0]  procOut = 8'h3c;
  logic [7:0]  faultEn = 8'h0f;
  logic [7:0]  faultVal = 8'h0a;
  logic [7:0]  chanOut;
  logic        runInd;
  logic        guardFail;
  logic [6:0]  stateCode;
  logic [10:0] lastId;
  logic [63:0] lastData;
  logic [31:0] rd;
  logic        slvErr;
  logic        tg;
  logic [7:0]  csTab [5] = '{8'h81, 8'h01, 8'h02, 8'h80, 8'h82};
  logic [6:0]  codeTab [5] = '{7'h7f, 7'h05, 7'h04, 7'h7f, 7'h7f};
  int          errTotal = 0;
  int          nCompared = 0;
  int          cnt;
  always #25 ref_clk = ~ref_clk;
  can_link_if link ();
  canopen_nmt_master canopen_nmt_master_i (.ref_clk(ref_clk), .reset(reset), .link(link.master),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  canopen_nmt_node #(.CHANNELS(8), .CYCLES_PER_MS(4)) canopen_nmt_node_i (.ref_clk(ref_clk),
    .reset(reset), .link(link.node), .nodeId(7'h05), .processOutputs(procOut), .faultEnable(faultEn),
    .faultValue(faultVal), .channelOutputs(chanOut), .run_indicator(runInd), .guardFailure(guardFail),
    .stateCode(stateCode));
  canopen_nmt_monitor canopen_nmt_monitor_i (.ref_clk(ref_clk), .reset(reset),
    .m2nValid(link.m2nValid), .m2nReady(link.m2nReady), .m2nId(link.m2nId), .m2nRtr(link.m2nRtr),
    .m2nDlc(link.m2nDlc), .m2nData(link.m2nData), .n2mValid(link.n2mValid), .n2mReady(link.n2mReady),
    .n2mId(link.n2mId), .n2mDlc(link.n2mDlc), .n2mData(link.n2mData));
  // ----------------------------------------
  // Frames taken from the node
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (link.n2mValid && link.n2mReady) begin
      lastId <= link.n2mId;
      lastData <= link.n2mData;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    if (!wr) begin
      rd = prdata;
    end
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cmd(input logic [31:0] w);
    apb(1'b1, 12'h000, w);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 40) begin
      @(posedge ref_clk);
      cnt++;
    end
    `CHK(irq, 1'b1)
    apb(1'b0, 12'h00c, 32'h0);
    apb(1'b1, 12'h010, 32'h7);
  endtask : cmd
  task nmt(input logic [7:0] cs);
    apb(1'b1, 12'h000, {16'h0, cs, 8'h01});
    repeat (8) @(posedge ref_clk);
  endtask : nmt
  task blink;
    logic prev;
    prev = runInd;
    cnt = 0;
    do begin
      @(posedge ref_clk);
      cnt++;
    end while (runInd === prev && cnt < 1100);
  endtask : blink
  task results;
    $display("Compared %0d, errors %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    results();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(stateCode, 7'h7f)
    blink();
    blink();
    `CHK(cnt, 1000)
    apb(1'b1, 12'h014, 32'h7);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(slvErr, 1'b1)
    apb(1'b1, 12'h008, 32'h6);
    nmt(8'h01);
    `CHK(stateCode, 7'h7f)
    apb(1'b1, 12'h008, 32'h5);
    nmt(8'h01);
    `CHK(stateCode, 7'h05)
    `CHK(chanOut, procOut)
    apb(1'b1, 12'h004, 32'h5);
    cmd({16'h100c, 13'h0, 3'h2});
    `CHK(lastData, 64'h0000_0000_0010_0c60)
    apb(1'b1, 12'h004, 32'h3);
    cmd({16'h100d, 13'h0, 3'h3});
    `CHK(rd[15:8], 8'h60)
    `CHK(lastData, 64'h0000_0000_0010_0d60)
    repeat (100) @(posedge ref_clk);
    `CHK(guardFail, 1'b0)
    apb(1'b1, 12'h000, 32'h4);
    repeat (40) @(posedge ref_clk);
    `CHK(guardFail, 1'b0)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rd[7:0], 8'h05)
    apb(1'b1, 12'h000, 32'h4);
    cnt = 0;
    while (guardFail !== 1'b1 && cnt < 100) begin
      @(posedge ref_clk);
      cnt++;
    end
    `CHK(cnt >= 54 && cnt <= 66, 1'b1)
    `CHK(guardFail, 1'b1)
    repeat (6) @(posedge ref_clk);
    `CHK(lastId, 11'h085)
    `CHK(lastData, 64'h0000_0000_0711_8130)
    `CHK(chanOut, 8'h3a)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rd[7:0], 8'h85)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd[2:0], 3'h5)
    apb(1'b1, 12'h010, 32'h7);
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd[2:0], 3'h0)
    `CHK(irq, 1'b0)
    tg = 1'b0;
    for (int i = 0; i < 5; i++) begin
      nmt(csTab[i]);
      if (csTab[i] > 8'h80) begin
        tg = 1'b0;
      end
      `CHK(stateCode, codeTab[i])
      cmd(32'h4);
      `CHK(rd[7:0], {tg, codeTab[i]})
      tg = ~tg;
    end
    `CHK(guardFail, 1'b0)
    results();
  end
endmodule : canopen_nmt_node_guarding_bench
